/* File: rtl/jts_pkg.sv */
// Constants and types for the boundary-scan instruction and scan-register block
// How it works
// - Three-bit instruction; all-clear drives ring out
// - Code 001 selects 32-bit identification word
// - Code 010 scans ring, floats memory outputs
// - Code 100 scans ring, memory untouched
// - Code 111 selects one-bit bypass register
// - Revision bits 31:29, part type 28:12
// - Bits 11:1 hold fixed maker code
// - Identification word bit zero reads one
// - Part type differs by word width
// - Cell 47 gates read drivers in external test
// - Cell 47 presets high at reset
// - Identification instruction current after any reset
// - Float holds until next instruction update, or cell 47 update in external test
package jts_pkg;

  // ----------------------------------------------------------------
  // Register sizes and cell positions
  // ----------------------------------------------------------------
  localparam int IR_LEN   = 3;     // Instruction register length
  localparam int ID_LEN   = 32;    // Identification register length
  localparam int BSR_LEN  = 107;   // Boundary scan register length
  localparam int OE_CELL  = 47;    // Internal read-driver enable cell

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [2:0] IR_EXTEST  = 3'h0;  // Drive ring from update latches
  localparam logic [2:0] IR_IDCODE  = 3'h1;  // Identification word
  localparam logic [2:0] IR_SAMPLEZ = 3'h2;  // Sample with outputs floated
  localparam logic [2:0] IR_SAMPLE  = 3'h4;  // Sample and preload
  localparam logic [2:0] IR_BYPASS  = 3'h7;  // One-bit bypass
  localparam logic [2:0] IR_CAP_PAT = 3'h1;  // Pattern captured into IR shifter

  // ----------------------------------------------------------------
  // Identification word fields (values arbitrary, not a real part)
  // ----------------------------------------------------------------
  localparam logic [2:0]  ID_REVISION  = 3'h2;      // Arbitrary revision
  localparam logic [16:0] ID_PART_NARW = 17'h0_1234; // Arbitrary narrow part type
  localparam logic [16:0] ID_PART_WIDE = 17'h0_1235; // Arbitrary wide part type
  localparam logic [10:0] ID_MAKER     = 11'h2a5;    // Arbitrary maker code
  localparam logic        ID_PRESENT   = 1'h1;      // Register present marker

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET  = 4'b0000, ST_IDLE   = 4'b0001, ST_SEL_DR = 4'b0010,
    ST_CAP_DR = 4'b0011, ST_SH_DR  = 4'b0100, ST_EX1_DR = 4'b0101,
    ST_PA_DR  = 4'b0110, ST_EX2_DR = 4'b0111, ST_UP_DR  = 4'b1000,
    ST_SEL_IR = 4'b1001, ST_CAP_IR = 4'b1010, ST_SH_IR  = 4'b1011,
    ST_EX1_IR = 4'b1100, ST_PA_IR  = 4'b1101, ST_EX2_IR = 4'b1110,
    ST_UP_IR  = 4'b1111
  } jts_state_e;

endpackage : jts_pkg

/* File: rtl/jts_tap.sv */
// Boundary-scan controller, instruction decode and scan registers
`timescale 1ns/10ps
`default_nettype none
module jts_tap
  import jts_pkg::*;
#(
  parameter bit WIDE_WORD = 1'b0  // Selects the wide-word part type
)(
  // System side
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  output logic                    q_oe_o,       // Memory read-data driver enable
  // Scan link
  input  wire logic               tck_i,
  input  wire logic               tms_i,
  input  wire logic               tdi_i,
  output logic                    tdo_o,
  output logic                    tdo_oe_o,
  // Pin ring
  input  wire logic [BSR_LEN-1:0] ring_in_i,    // Pin levels, asynchronous
  output logic [BSR_LEN-1:0]      ring_drive_o, // Update latches
  output logic                    extest_o      // Ring driven from latches
);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef struct packed {
    jts_state_e         st;      // Controller state
    logic [IR_LEN-1:0]  ir_sh;   // Instruction shifter
    logic [IR_LEN-1:0]  ir;      // Current instruction
    logic               byp;     // Bypass cell
    logic [ID_LEN-1:0]  id_sh;   // Identification shifter
    logic [BSR_LEN-1:0] bsr_sh;  // Boundary shifter
    logic [BSR_LEN-1:0] upd;     // Boundary update latches
    logic [BSR_LEN-1:0] ring_s1; // Pin sync stage one
    logic [BSR_LEN-1:0] ring_s2; // Pin sync stage two
    logic               extest;  // Ring drive active
    logic               q_float; // Read drivers to float
  } jts_tck_s;

  typedef struct packed {
    logic tdo;     // Serial out
    logic tdo_oe;  // Serial out enable
  } jts_neg_s;

  typedef struct packed {
    logic fl_s1;   // Float sync stage one
    logic fl_s2;   // Float sync stage two
    logic q_oe;    // Registered driver enable
  } jts_sys_s;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  jts_tck_s   s,  next_s;    // Link domain state
  jts_neg_s   n,  next_n;    // Falling-edge state
  jts_sys_s   y,  next_y;    // System domain state
  logic [1:0] rst_sync;      // Link-domain reset release
  logic       rst_tck_n;     // Synchronised link reset
  logic [31:0] id_word;      // Fixed identification word

  assign rst_tck_n = rst_sync[1];

  // Identification word assembly
  assign id_word = {ID_REVISION,
                    (WIDE_WORD ? ID_PART_WIDE : ID_PART_NARW),
                    ID_MAKER,
                    ID_PRESENT};

  // ----------------------------------------------------------------
  // Link reset synchroniser
  // ----------------------------------------------------------------
  // Asserts at once, releases on link clock
  always_ff @(posedge tck_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // ----------------------------------------------------------------
  // Controller and scan registers, next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s         = s;
    // Pin ring sync, two stages
    next_s.ring_s1 = ring_in_i;
    next_s.ring_s2 = s.ring_s1;
    // State walk on sampled mode select
    case (s.st)
      ST_RESET:  next_s.st = tms_i ? ST_RESET  : ST_IDLE;
      ST_IDLE:   next_s.st = tms_i ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_s.st = tms_i ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_s.st = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_s.st = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_s.st = tms_i ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  next_s.st = tms_i ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_s.st = tms_i ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  next_s.st = tms_i ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_s.st = tms_i ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: next_s.st = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_s.st = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_s.st = tms_i ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  next_s.st = tms_i ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_s.st = tms_i ? ST_UP_IR  : ST_SH_IR;
      default:   next_s.st = tms_i ? ST_SEL_DR : ST_IDLE;
    endcase
    // Per-state actions
    case (s.st)
      // Reset state: default instruction, enable cell preset
      ST_RESET:
      begin
        next_s.ir           = IR_IDCODE;
        next_s.upd[OE_CELL] = 1'b1;
      end
      // Instruction shifter
      ST_CAP_IR: next_s.ir_sh = IR_CAP_PAT;
      ST_SH_IR:  next_s.ir_sh = {tdi_i, s.ir_sh[IR_LEN-1:1]};
      ST_UP_IR:  next_s.ir    = s.ir_sh;
      // Data register capture per instruction
      ST_CAP_DR:
      begin
        case (s.ir)
          IR_IDCODE: next_s.id_sh = id_word;
          IR_EXTEST, IR_SAMPLEZ, IR_SAMPLE:
          begin
            next_s.bsr_sh          = s.ring_s2;
            next_s.bsr_sh[OE_CELL] = s.upd[OE_CELL];
          end
          // Bypass, also for unused codes
          default:   next_s.byp = 1'b0;
        endcase
      end
      // Data register shift per instruction
      ST_SH_DR:
      begin
        case (s.ir)
          IR_IDCODE: next_s.id_sh = {tdi_i, s.id_sh[ID_LEN-1:1]};
          IR_EXTEST, IR_SAMPLEZ, IR_SAMPLE:
            next_s.bsr_sh = {tdi_i, s.bsr_sh[BSR_LEN-1:1]};
          default:   next_s.byp = tdi_i;
        endcase
      end
      // Boundary update latches
      ST_UP_DR:
      begin
        if (s.ir == IR_EXTEST || s.ir == IR_SAMPLEZ || s.ir == IR_SAMPLE)
          next_s.upd = s.bsr_sh;
      end
      default: ;
    endcase
    // Driver controls from the instruction taking effect
    next_s.extest  = (next_s.ir == IR_EXTEST);
    next_s.q_float = (next_s.ir == IR_SAMPLEZ) ||
                     ((next_s.ir == IR_EXTEST) && !next_s.upd[OE_CELL]);
  end

  // Link domain registers
  always_ff @(posedge tck_i or negedge rst_tck_n)
  begin
    if (!rst_tck_n)
    begin
      s              <= '0;
      s.st           <= ST_RESET;
      s.ir           <= IR_IDCODE;
      s.upd[OE_CELL] <= 1'b1;
      s.byp          <= 1'b0;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // Serial output on falling edge
  // ----------------------------------------------------------------
  always_comb
  begin
    next_n = n;
    if (s.st == ST_SH_IR)
    begin
      next_n.tdo    = s.ir_sh[0];
      next_n.tdo_oe = 1'b1;
    end
    else if (s.st == ST_SH_DR)
    begin
      next_n.tdo_oe = 1'b1;
      case (s.ir)
        IR_IDCODE: next_n.tdo = s.id_sh[0];
        IR_EXTEST, IR_SAMPLEZ, IR_SAMPLE: next_n.tdo = s.bsr_sh[0];
        default:   next_n.tdo = s.byp;
      endcase
    end
    else
      next_n.tdo_oe = 1'b0;
  end

  // Falling-edge registers
  always_ff @(negedge tck_i or negedge rst_tck_n)
  begin
    if (!rst_tck_n)
      n <= '0;
    else
      n <= next_n;
  end

  // ----------------------------------------------------------------
  // System domain: float request crossing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_y       = y;
    next_y.fl_s1 = s.q_float;
    next_y.fl_s2 = y.fl_s1;
    next_y.q_oe  = !y.fl_s2;
  end

  // System registers, drivers enabled after power-up
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      y      <= '0;
      y.q_oe <= 1'b1;
    end
    else
      y <= next_y;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign q_oe_o       = y.q_oe;
  assign tdo_o        = n.tdo;
  assign tdo_oe_o     = n.tdo_oe;
  assign ring_drive_o = s.upd;
  assign extest_o     = s.extest;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_idcode: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st == ST_RESET |=> s.ir == IR_IDCODE) else $error("reset left wrong instruction");
  a_reset_oecell: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st == ST_RESET |=> s.upd[OE_CELL]) else $error("enable cell not preset");
  a_ir_update: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st == ST_UP_IR |=> s.ir == $past(s.ir_sh)) else $error("instruction not updated");
  a_ir_holds: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st != ST_UP_IR && s.st != ST_RESET |=> $stable(s.ir)) else $error("instruction moved");
  a_id_capture: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st == ST_CAP_DR && s.ir == IR_IDCODE |=> s.id_sh == id_word) else $error("bad id");
  a_id_fields: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st == ST_CAP_DR && s.ir == IR_IDCODE |=> s.id_sh[31:29] == ID_REVISION)
    else $error("bad revision");
  a_id_maker: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st == ST_CAP_DR && s.ir == IR_IDCODE |=> s.id_sh[11:1] == ID_MAKER && s.id_sh[0])
    else $error("bad maker or presence bit");
  a_bypass_cap: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st == ST_CAP_DR && s.ir == IR_BYPASS |=> !s.byp) else $error("bypass not cleared");
  a_bsr_capture: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st == ST_CAP_DR && s.ir == IR_SAMPLE |=> s.bsr_sh[0] == $past(s.ring_s2[0]))
    else $error("ring not captured");
  a_float_samplez: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.ir == IR_SAMPLEZ |-> s.q_float) else $error("sample-z not floating");
  a_float_cell: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.ir == IR_EXTEST |-> s.q_float == !s.upd[OE_CELL]) else $error("cell 47 ignored");
  a_tdo_enable: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st == ST_SH_DR || s.st == ST_SH_IR |-> tdo_oe_o) else $error("tdo not driven");
  a_q_oe_sync: assert property (@(posedge clk_i) disable iff (!resetn_i)
    y.fl_s2 |=> !q_oe_o) else $error("read drivers not floated");

  c_idcode_shift: cover property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.ir == IR_IDCODE && s.st == ST_SH_DR);
  c_samplez: cover property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.st == ST_UP_IR ##1 s.ir == IR_SAMPLEZ);
  c_extest_float: cover property (@(posedge tck_i) disable iff (!rst_tck_n)
    s.ir == IR_EXTEST && !s.upd[OE_CELL]);
  c_q_float: cover property (@(posedge clk_i) disable iff (!resetn_i) !q_oe_o);

endmodule // jts_tap
`default_nettype wire

/* File: verification/jts_ctl_model.sv */
// Behavioural boundary-scan test controller driving the scan link
`timescale 1ns/10ps
`default_nettype none
module jts_ctl_model
  import jts_pkg::*;
(
  // Scan link
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o,
  input  wire logic tdo_i,  // Narrow-word device
  input  wire logic tdo2_i  // Wide-word device
);
  // --------------------------------------------------------------
  // Link idles with the scan clock parked low
  // --------------------------------------------------------------
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One scan clock: inputs move after the fall, tdo read before the rise
  task automatic step(input logic m, input logic d, output logic a, output logic b);
    tms_o = m;
    tdi_o = d;
    #7.5;
    a = tdo_i;
    b = tdo2_i;
    tck_o = 1'b1;
    #7.5;
    tck_o = 1'b0;
  endtask

  // Header walk, n shift bits, update, then idle; idle tdi keeps toggling
  task automatic frame(input logic [3:0] hdr, input int hn, input int n,
                       input logic [106:0] din, output logic [106:0] qa,
                       output logic [106:0] qb);
    logic a;
    logic b;
    qa = '0;
    qb = '0;
    #3;
    for (int i = 0; i < hn; i++)
      step(hdr[i], ~tdi_o, a, b);
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], qa[i], qb[i]);
    step(1'b1, ~tdi_o, a, b);
    repeat (3)
      step(1'b0, ~tdi_o, a, b);
  endtask

  // Five high mode bits reach reset, then park in idle
  task automatic tlr();
    logic a;
    logic b;
    #3;
    repeat (5)
      step(1'b1, ~tdi_o, a, b);
    repeat (2)
      step(1'b0, ~tdi_o, a, b);
  endtask

  // Instruction load, returns the captured instruction bits
  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic [106:0] qa;
    logic [106:0] qb;
    if (code inside {3'h3, 3'h5, 3'h6})
      code = IR_BYPASS;
    frame(4'h3, 4, 3, {104'h0, code}, qa, qb);
    cap = qa[2:0];
  endtask
endmodule // jts_ctl_model
`default_nettype wire

/* File: verification/jts_tap_tb.sv */
// Self-checking bench for the scan instruction and register block
`timescale 1ns/10ps
`default_nettype none
module jts_tap_tb
  import jts_pkg::*;
;
  // --------------------------------------------------------------
  // Signals and expected patterns
  // --------------------------------------------------------------
  logic               clk_i;
  logic               resetn_i;
  logic [BSR_LEN-1:0] ring_in;     // Pin levels offered to capture
  logic [BSR_LEN-1:0] ring_drive;  // Update latches
  logic               q_oe;        // Read driver enable
  logic               extest;      // Ring driven from latches
  logic               tck;
  logic               tms;
  logic               tdi;
  logic               tdo;
  logic               tdo_w;       // Wide-word device output
  logic               tdo_oe;
  logic [106:0]       qa;          // Bits shifted out, narrow
  logic [106:0]       qb;          // Bits shifted out, wide
  logic [2:0]         cap;         // Captured instruction bits
  int                 miscompares = 0;
  int                 samples_checked = 0;
  int                 cycles = 0;
  localparam logic [BSR_LEN-1:0] RING = {{26{4'h6}}, 3'h5};
  localparam logic [BSR_LEN-1:0] PAT  = {{26{4'ha}}, 3'h3};  // Cell 47 low
  localparam logic [BSR_LEN-1:0] OE1  = {{59{1'b0}}, 1'b1, {47{1'b0}}};
  localparam logic [31:0]        ID_N = {ID_REVISION, ID_PART_NARW, ID_MAKER, 1'b1};
  localparam logic [31:0]        ID_W = {ID_REVISION, ID_PART_WIDE, ID_MAKER, 1'b1};

  jts_tap #(.WIDE_WORD(1'b0)) jts_tap_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .q_oe_o(q_oe), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ring_in_i(ring_in),
    .ring_drive_o(ring_drive), .extest_o(extest));
  jts_tap #(.WIDE_WORD(1'b1)) jts_tap_inst_wide (
    .clk_i(clk_i), .resetn_i(resetn_i), .q_oe_o(), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo_w), .tdo_oe_o(), .ring_in_i(ring_in),
    .ring_drive_o(), .extest_o());
  jts_ctl_model jts_ctl_model_inst (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo2_i(tdo_w));

  // --------------------------------------------------------------
  // Clock, timeout and helpers
  // --------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [106:0] got, input logic [106:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check({106'h0, got}, {106'h0, exp});
  endtask

  // Enough system clocks for the enable to cross
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask

  task automatic ir(input logic [2:0] code);
    jts_ctl_model_inst.load_ir(code, cap);
    check({104'h0, cap}, {104'h0, IR_CAP_PAT});
  endtask

  task automatic dr(input int n, input logic [106:0] din);
    jts_ctl_model_inst.frame(4'h1, 3, n, din, qa, qb);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_id();
    dr(ID_LEN, '1);
    check(qa, {75'h0, ID_N});
    check(qb, {75'h0, ID_W});
  endtask

  task automatic t_bypass();
    ir(IR_BYPASS);
    dr(8, 107'hb4);
    check(qa, 107'h68);
    settle();
    check1(q_oe, 1'b1);
  endtask

  task automatic t_sample();
    @(posedge clk_i);
    ring_in <= RING;
    ir(IR_SAMPLE);
    dr(BSR_LEN, PAT);
    check(qa, {RING[106:48], 1'b1, RING[46:0]});
    check(ring_drive, PAT);
    check1(extest, 1'b0);
    settle();
    check1(q_oe, 1'b1);
  endtask

  task automatic t_extest();
    ir(IR_EXTEST);
    check1(extest, 1'b1);
    settle();
    check1(q_oe, 1'b0);
    dr(BSR_LEN, ~PAT);
    check(qa, {RING[106:48], 1'b0, RING[46:0]});
    check(ring_drive, ~PAT);
    settle();
    check1(q_oe, 1'b1);
  endtask

  task automatic t_samplez();
    ir(IR_SAMPLEZ);
    settle();
    check1(q_oe, 1'b0);
    check1(extest, 1'b0);
    dr(BSR_LEN, PAT);
    check(qa, {RING[106:48], 1'b1, RING[46:0]});
    settle();
    check1(q_oe, 1'b0);
  endtask

  task automatic t_tlr();
    jts_ctl_model_inst.tlr();
    // Only the enable cell presets; the other latches keep the last update
    check(ring_drive, PAT | OE1);
    check1(extest, 1'b0);
    settle();
    check1(q_oe, 1'b1);
    t_id();
  endtask

  // Main sequence: reset with scan clocks running, then each scenario
  initial
  begin
    resetn_i = 1'b0;
    ring_in  = '0;
    fork
      repeat (10) @(posedge clk_i);
      jts_ctl_model_inst.tlr();
    join
    check(ring_drive, OE1);
    check1(q_oe, 1'b1);
    check1(tdo_oe, 1'b0);
    resetn_i <= 1'b1;
    jts_ctl_model_inst.tlr();
    t_id();
    t_bypass();
    t_sample();
    t_extest();
    t_samplez();
    t_tlr();
    stop_test();
  end
endmodule // jts_tap_tb
`default_nettype wire
